//--- logic/core_timer_pkg.sv
// Package for the core timer with periodic interrupt and watchdog.
// Assumes an APB slave with 32-bit data and one word per register.
`default_nettype none
package core_timer_pkg;
   // Register byte offsets.
   localparam logic [11:0] OFS_STATUS_CONTROL = 12'h0000;
   localparam logic [11:0] OFS_COUNT          = 12'h0004;
   localparam logic [11:0] OFS_WATCHDOG       = 12'h0008;
   localparam logic [11:0] OFS_OPTION         = 12'h000C;
   // Status and control field positions.
   localparam int BIT_CORE_FLAG     = 7;
   localparam int BIT_PER_FLAG      = 6;
   localparam int BIT_CORE_IEN      = 5;
   localparam int BIT_PER_IEN       = 4;
   localparam int BIT_CORE_CLR      = 3;
   localparam int BIT_PER_CLR       = 2;
   localparam int BIT_RATE_HI       = 1;
   localparam int BIT_RATE_LO       = 0;
   // Watchdog register field positions.
   localparam int BIT_WDOG_CLEAR    = 0;
   // Option register field positions.
   localparam int BIT_OPT_WDOG_EN   = 0;
   localparam int BIT_OPT_STOP_HALT = 1;
   localparam int BIT_OPT_LONG_DLY  = 2;
   // Reset values.
   localparam logic [1:0] RATE_RESET   = 2'h3;
   localparam logic [2:0] OPTION_RESET = 3'h0;
   // Timing counts; the startup delays are given in bus cycles and scaled to oscillator cycles.
   localparam int PRESCALE_DIV      = 8;
   localparam int CHAIN_STAGES      = 15;
   localparam int WDOG_STAGES       = 4;
   localparam int WDOG_TIMEOUT      = 7;
   localparam int BUS_PER_OSC       = 2;
   localparam int DELAY_SHORT_BUS   = 16;
   localparam int DELAY_LONG_BUS    = 4064;
   localparam int DELAY_SHORT       = DELAY_SHORT_BUS * BUS_PER_OSC;
   localparam int DELAY_LONG        = DELAY_LONG_BUS * BUS_PER_OSC;
   // Startup states.
   typedef enum logic [2:0]
   {
      ST_POWER = 3'b001,
      ST_DELAY = 3'b010,
      ST_RUN   = 3'b100
   } start_t;
endpackage
`default_nettype wire

//--- logic/core_timer.sv
// Core timer: prescaled counter chain, overflow and periodic flags, watchdog.
// Assumes CLK is the oscillator clock at 40 MHz and the registers sit on APB.
// Function
// RULE1: Set overflow flag when low byte wraps.
// RULE2: Overflow interrupt while flag and enable set.
// RULE3: Writing one to clear bit clears flag.
// RULE4: Periodic flag on tap, interrupt when enabled.
// RULE5: Writing one clears periodic flag.
// RULE6: Reset clears flags, enables; sets rates.
// RULE7: Flag clear bits write-only, read zero.
// RULE8: Rate select picks divide by 2^15..2^18.
// RULE9: Selected tap also clocks the watchdog.
// RULE10: Watchdog times out after seven to eight periods.
// RULE11: Fifteen stages after divide-by-eight, low byte readable.
// RULE12: Count every eight cycles, overflow every 2048.
// RULE13: Clear chain at power-on and at release.
// RULE14: Watchdog is final stages, option enabled.
// RULE15: Watchdog timeout resets the whole controller.
// RULE16: Writing zero to watchdog clear restarts it.
// RULE17: Watchdog runs in run, wait, halt; stop clears.
// RULE18: Stop-to-halt option keeps stop as halt.
// RULE19: High-voltage detector holds watchdog off.
// RULE20: Software clears watchdog before changing rates.
// RULE21: Software clears watchdog before wait or halt.
// RULE22: Tap rising edge sets flag, steps watchdog.
// RULE23: Watchdog clear touches only watchdog stages.
`timescale 1ns/1ps
`default_nettype none
module core_timer
(
   input  wire  logic        CLK,
   input  wire  logic        RST,
   input  wire  logic        PSEL,
   input  wire  logic        PENABLE,
   input  wire  logic        PWRITE,
   input  wire  logic [11:0] PADDR,
   input  wire  logic [31:0] PWDATA,
   output var   logic [31:0] PRDATA,
   output var   logic        PREADY,
   output var   logic        PSLVERR,
   input  wire  logic        STOP_EXEC,
   input  wire  logic        HV_DETECT,
   output var   logic        CORE_IRQ,
   output var   logic        PERIODIC_IRQ,
   output var   logic        WATCHDOG_RESET,
   output var   logic        STOP_ACTIVE,
   output var   logic        CPU_RESET
);

   //==========================================================================
   // State record
   //==========================================================================
   // All state of the block lives in this struct.
   typedef struct packed
   {
      core_timer_pkg::start_t   start;       // Startup sequence state.
      logic [12:0]              delay;       // Startup delay counter.
      logic [2:0]               prescale;    // Divide-by-eight prescaler.
      logic [14:0]              chain;       // Core counter chain.
      logic                     tap_last;    // Selected tap from last cycle.
      logic [3:0]               wdog;        // Watchdog stages.
      logic                     core_flag;   // Overflow flag.
      logic                     per_flag;    // Periodic flag.
      logic                     core_ien;    // Overflow interrupt enable.
      logic                     per_ien;     // Periodic interrupt enable.
      logic [1:0]               rate;        // Rate select.
      logic [2:0]               option;      // Option bits.
      logic                     stopped;     // Stop mode in effect.
      logic [31:0]              rdata;       // Read data register.
      logic                     ready;       // Ready register.
      logic                     slverr;      // Error register.
      logic                     core_irq;    // Overflow interrupt output.
      logic                     per_irq;     // Periodic interrupt output.
      logic                     wdog_rst;    // Watchdog reset pulse.
      logic                     cpu_rst;     // Controller reset level.
   } state_t;

   state_t st;       // Registered state.
   state_t next_st;  // Next state.

   // Selects the periodic tap for a rate setting.
   function automatic logic tap_of(input logic [14:0] c, input logic [1:0] r);
      logic t;
      t = 1'b0;
      case (r)
         2'h0:    t = c[11];
         2'h1:    t = c[12];
         2'h2:    t = c[13];
         default: t = c[14];
      endcase
      return t;
   endfunction

   logic        setup;     // APB access phase qualifier.
   logic        wr;        // Write access in this cycle.
   logic        rd;        // Read access in this cycle.
   logic        tick;      // Prescaler carry.
   logic        tap;       // Selected periodic tap.
   logic        tap_rise;  // Rising edge of the tap.
   logic        wdog_run;  // Watchdog is allowed to count.
   logic        timeout;   // Watchdog reaches its timeout.
   logic [12:0] delay_end; // Startup delay length.

   //==========================================================================
   // Next-state logic
   //==========================================================================
   // Computes the whole next state in one pass.
   always_comb
   begin
      next_st   = st;
      setup     = PSEL && PENABLE;
      // Writes land only at the edge that also samples PREADY high.
      wr        = setup && PWRITE && st.ready;
      rd        = setup && !PWRITE;
      tick      = (st.prescale == 3'h7);
      tap       = tap_of(st.chain, st.rate);
      tap_rise  = tap && !st.tap_last;
      delay_end = st.option[core_timer_pkg::BIT_OPT_LONG_DLY]
                  ? 13'(core_timer_pkg::DELAY_LONG) : 13'(core_timer_pkg::DELAY_SHORT);
      wdog_run  = st.option[core_timer_pkg::BIT_OPT_WDOG_EN] && !st.stopped
                  && !HV_DETECT && (st.start == core_timer_pkg::ST_RUN);  // see RULE14 see RULE19
      timeout   = wdog_run && tap_rise
                  && (st.wdog == 4'(core_timer_pkg::WDOG_TIMEOUT));        // see RULE10
      next_st.wdog_rst = 1'b0;
      next_st.ready    = 1'b0;
      next_st.slverr   = 1'b0;
      // Read data stands for the answer cycle only.
      next_st.rdata    = 32'h0000_0000;

      // Counter chain: prescaler then fifteen stages.
      next_st.prescale = st.prescale + 3'h1;                   // see RULE11
      if (tick)
      begin
         next_st.chain = st.chain + 15'h0001;                  // see RULE12
      end
      next_st.tap_last = tap;

      // Overflow of the low eight stages.
      if (tick && (st.chain[7:0] == 8'hFF))
      begin
         next_st.core_flag = 1'b1;                             // see RULE1
      end
      else if (wr && (PADDR == core_timer_pkg::OFS_STATUS_CONTROL)
               && PWDATA[core_timer_pkg::BIT_CORE_CLR])
      begin
         next_st.core_flag = 1'b0;                             // see RULE3
      end

      // Periodic flag on a rising tap.
      if (tap_rise)
      begin
         next_st.per_flag = 1'b1;                              // see RULE4 see RULE22 see RULE9
      end
      else if (wr && (PADDR == core_timer_pkg::OFS_STATUS_CONTROL)
               && PWDATA[core_timer_pkg::BIT_PER_CLR])
      begin
         next_st.per_flag = 1'b0;                              // see RULE5
      end

      // Stop mode: stop acts as halt when the option says so.
      if (STOP_EXEC && !st.option[core_timer_pkg::BIT_OPT_STOP_HALT])
      begin
         next_st.stopped = 1'b1;                               // see RULE18
      end
      else if (!STOP_EXEC)
      begin
         next_st.stopped = 1'b0;
      end

      // Watchdog stages count on the tap edge.
      if (!wdog_run || (st.stopped))
      begin
         next_st.wdog = 4'h0;                                  // see RULE17
      end
      else if (wr && (PADDR == core_timer_pkg::OFS_WATCHDOG)
               && !PWDATA[core_timer_pkg::BIT_WDOG_CLEAR])
      begin
         next_st.wdog = 4'h0;                                  // see RULE16 see RULE23
      end
      else if (timeout)
      begin
         next_st.wdog     = 4'h0;
         next_st.wdog_rst = 1'b1;                              // see RULE15
      end
      else if (tap_rise)
      begin
         next_st.wdog = st.wdog + 4'h1;                        // see RULE22
      end

      // Startup: clear chain at power-on and again at release.
      case (st.start)
         core_timer_pkg::ST_POWER:
         begin
            next_st.chain   = 15'h0000;                        // see RULE13
            next_st.delay   = 13'h0000;
            next_st.start   = core_timer_pkg::ST_DELAY;
            next_st.cpu_rst = 1'b1;
         end
         core_timer_pkg::ST_DELAY:
         begin
            next_st.delay = st.delay + 13'h0001;
            if (st.delay >= delay_end - 13'h0001)
            begin
               next_st.chain    = 15'h0000;                    // see RULE13
               next_st.prescale = 3'h0;
               next_st.start    = core_timer_pkg::ST_RUN;
               next_st.cpu_rst  = 1'b0;
            end
         end
         core_timer_pkg::ST_RUN:
         begin
            next_st.cpu_rst = next_st.wdog_rst;
         end
         default:
         begin
            next_st.start = core_timer_pkg::ST_POWER;
         end
      endcase

      // APB writes to control and option bits.
      if (wr && (PADDR == core_timer_pkg::OFS_STATUS_CONTROL))
      begin
         next_st.core_ien = PWDATA[core_timer_pkg::BIT_CORE_IEN];
         next_st.per_ien  = PWDATA[core_timer_pkg::BIT_PER_IEN];
         next_st.rate     = {PWDATA[core_timer_pkg::BIT_RATE_HI],
                             PWDATA[core_timer_pkg::BIT_RATE_LO]};  // see RULE8
      end
      else if (wr && (PADDR == core_timer_pkg::OFS_OPTION))
      begin
         next_st.option = PWDATA[2:0];
      end

      // APB answer in the access phase.
      if (setup && !st.ready)
      begin
         next_st.ready = 1'b1;
         next_st.rdata = 32'h0000_0000;
         if (PADDR == core_timer_pkg::OFS_STATUS_CONTROL)
         begin
            // Clear bits read as zero.
            next_st.rdata[7:0] = {st.core_flag, st.per_flag, st.core_ien, st.per_ien,
                                  2'b00, st.rate};            // see RULE7
         end
         else if (PADDR == core_timer_pkg::OFS_COUNT)
         begin
            next_st.rdata[7:0] = st.chain[7:0];                // see RULE11
         end
         else if (PADDR == core_timer_pkg::OFS_WATCHDOG)
         begin
            next_st.rdata = 32'h0000_0000;
         end
         else if (PADDR == core_timer_pkg::OFS_OPTION)
         begin
            next_st.rdata[2:0] = st.option;
         end
         else
         begin
            next_st.slverr = 1'b1;
         end
         if (!rd)
         begin
            next_st.rdata = 32'h0000_0000;
         end
      end

      next_st.core_irq = next_st.core_flag && next_st.core_ien;  // see RULE2
      next_st.per_irq  = next_st.per_flag && next_st.per_ien;    // see RULE4
   end

   //==========================================================================
   // State register
   //==========================================================================
   // Registers the state; reset clears flags, enables, and sets both rates.
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         st          <= '0;
         st.start    <= core_timer_pkg::ST_POWER;
         st.rate     <= core_timer_pkg::RATE_RESET;            // see RULE6
         st.option   <= core_timer_pkg::OPTION_RESET;
         st.cpu_rst  <= 1'b1;
      end
      else
      begin
         st <= next_st;
      end
   end

   // The answer comes one cycle after the access phase; writes commit with it.
   assign PRDATA         = st.rdata;
   assign PREADY         = st.ready;
   assign PSLVERR        = st.slverr;
   assign CORE_IRQ       = st.core_irq;
   assign PERIODIC_IRQ   = st.per_irq;
   assign WATCHDOG_RESET = st.wdog_rst;
   assign STOP_ACTIVE    = st.stopped;
   assign CPU_RESET      = st.cpu_rst;

   //==========================================================================
   // Checks
   //==========================================================================
   // Each interrupt output equals its flag and enable in every cycle.
   a_core_irq_gate: assert property (@(posedge CLK) disable iff (RST)  // see RULE2
      CORE_IRQ == (st.core_flag && st.core_ien))
      else $error("core irq mismatch");
   a_per_irq_gate: assert property (@(posedge CLK) disable iff (RST)   // see RULE4
      PERIODIC_IRQ == (st.per_flag && st.per_ien))
      else $error("periodic irq mismatch");
   // Flags: a set event always lands; a clear lands unless a set competes.
   a_overflow_set: assert property (@(posedge CLK) disable iff (RST)   // see RULE1
      (tick && st.chain[7:0] == 8'hFF) |=> st.core_flag)
      else $error("overflow flag not set");
   a_core_clear: assert property (@(posedge CLK) disable iff (RST)     // see RULE3
      (wr && PADDR == core_timer_pkg::OFS_STATUS_CONTROL && PWDATA[3]
       && !(tick && st.chain[7:0] == 8'hFF)) |=> !st.core_flag)
      else $error("overflow flag not cleared");
   a_per_clear: assert property (@(posedge CLK) disable iff (RST)      // see RULE5
      (wr && PADDR == core_timer_pkg::OFS_STATUS_CONTROL && PWDATA[2]
       && !tap_rise) |=> !st.per_flag)
      else $error("periodic flag not cleared");
   a_clear_reads_zero: assert property (@(posedge CLK) disable iff (RST)  // see RULE7
      (PREADY && $past(PADDR) == core_timer_pkg::OFS_STATUS_CONTROL)
      |-> PRDATA[3:2] == 2'b00)
      else $error("clear bits read nonzero");
   a_count_step: assert property (@(posedge CLK) disable iff (RST)     // see RULE12
      (st.start == core_timer_pkg::ST_RUN && tick && $past(st.start) == core_timer_pkg::ST_RUN)
      |=> st.chain == $past(st.chain) + 15'h0001)
      else $error("counter did not step");
   // Watchdog: a clear write beats a timeout in the same cycle.
   a_wdog_clear: assert property (@(posedge CLK) disable iff (RST)     // see RULE16
      (wr && PADDR == core_timer_pkg::OFS_WATCHDOG && !PWDATA[0]) |=> st.wdog == 4'h0)
      else $error("watchdog not cleared");
   a_hv_holds_off: assert property (@(posedge CLK) disable iff (RST)   // see RULE19
      HV_DETECT |=> st.wdog == 4'h0 && !WATCHDOG_RESET)
      else $error("watchdog ran under high voltage");
   a_timeout_reset: assert property (@(posedge CLK) disable iff (RST)  // see RULE15
      (timeout && !(wr && PADDR == core_timer_pkg::OFS_WATCHDOG && !PWDATA[0]))
      |=> WATCHDOG_RESET && CPU_RESET)
      else $error("timeout gave no reset");

endmodule
`default_nettype wire

//--- tb/tb_core_timer.sv
// Self-checking bench for the core timer, driven through its APB slave port.
// Assumes the core_timer_pkg package is compiled first and CLK runs at 40 MHz.
`timescale 1ns/1ps
`default_nettype none
module tb_core_timer;
   // ==========================================================================
   // Stimulus signals, counters and the design instance
   // ==========================================================================
   localparam int LIMIT = 90000;    // Cycle ceiling, above the longest test path.
   logic        clk;                // Oscillator clock.
   logic        rst;                // Asynchronous reset, active high.
   logic        psel;               // APB select.
   logic        penable;            // APB access phase.
   logic        pwrite;             // APB direction.
   logic [11:0] paddr;              // APB byte address.
   logic [31:0] pwdata;             // APB write data.
   wire  [31:0] prdata;             // APB read data.
   wire         pready;             // APB answer strobe.
   wire         pslverr;            // APB error strobe.
   logic        stop_exec;          // Stop instruction in effect.
   logic        hv_detect;          // High-voltage detector level.
   wire         core_irq;           // Overflow interrupt request.
   wire         periodic_irq;       // Periodic interrupt request.
   wire         watchdog_reset;     // Watchdog timeout pulse.
   wire         stop_active;        // Stop honoured by the watchdog.
   wire         cpu_reset;          // Controller reset level.
   int          fail_count = 0;     // Mismatches seen.
   int          cmp_count = 0;      // Comparisons made.
   int          cyc = 0;            // Free-running cycle count.
   int          t1;                 // Cycle of one periodic request.
   int          t2;                 // Cycle of the next periodic request.
   logic [31:0] rdv;                // Last read data.
   logic [31:0] cnt_a;              // First counter sample.
   logic        errv;               // Last error response.
   logic        wd_seen = 1'b0;     // Set once a watchdog pulse appears.

   core_timer uut
   (
      .CLK            (clk),
      .RST            (rst),
      .PSEL           (psel),
      .PENABLE        (penable),
      .PWRITE         (pwrite),
      .PADDR          (paddr),
      .PWDATA         (pwdata),
      .PRDATA         (prdata),
      .PREADY         (pready),
      .PSLVERR        (pslverr),
      .STOP_EXEC      (stop_exec),
      .HV_DETECT      (hv_detect),
      .CORE_IRQ       (core_irq),
      .PERIODIC_IRQ   (periodic_irq),
      .WATCHDOG_RESET (watchdog_reset),
      .STOP_ACTIVE    (stop_active),
      .CPU_RESET      (cpu_reset)
   );

   // The clock toggles every half period of 12.5 ns.
   always #12.5 clk = ~clk;

   // Counts cycles, records any watchdog pulse and cuts a hang short.
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (watchdog_reset === 1'b1)
      begin
         wd_seen <= 1'b1;
      end
      if (cyc == LIMIT)
      begin
         fail_count++;
         final_report();
      end
   end

   // ==========================================================================
   // Tasks
   // ==========================================================================
   // Prints the counts and the verdict, then ends the run.
   task automatic final_report();
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // Compares one result against its expected value.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         fail_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One APB transfer: setup, access, then hold until pready is sampled high.
   task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      rdv = prdata;
      errv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20)
      begin
         chk(32'h0000_0000, 32'h0000_0001);
      end
   endtask

   // Reads a register and compares the bits selected by the mask.
   task automatic rd_chk(input logic [11:0] addr, input logic [31:0] mask,
                         input logic [31:0] exp);
      apb(1'b0, addr, 32'h0000_0000);
      chk(rdv & mask, exp);
   endtask

   // Waits for the periodic request to rise and notes the cycle.
   task automatic wait_irq(output int t);
      int n;
      n = 0;
      while (periodic_irq !== 1'b1 && n < 40000)
      begin
         @(posedge clk);
         n++;
      end
      t = cyc;
      if (n >= 40000)
      begin
         chk(32'h0000_0000, 32'h0000_0001);
      end
   endtask

   // ==========================================================================
   // Main sequence
   // ==========================================================================
   initial
   begin
      clk = 1'b0;
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      stop_exec = 1'b0;
      hv_detect = 1'b0;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      // Startup: wait out the short delay before touching the registers.
      repeat (200) @(posedge clk) if (cpu_reset === 1'b0) break;
      chk({31'h0, cpu_reset}, 32'h0000_0000);
      rd_chk(core_timer_pkg::OFS_STATUS_CONTROL, 32'hFFFF_FFFF, 32'h0000_0003);
      rd_chk(core_timer_pkg::OFS_OPTION, 32'hFFFF_FFFF, 32'h0000_0000);
      $display("test reset values done");
      // Counter reads 32 cycles apart differ by exactly four steps.
      rd_chk(core_timer_pkg::OFS_COUNT, 32'hFFFF_FF00, 32'h0000_0000);
      cnt_a = rdv;
      repeat (28) @(posedge clk);
      apb(1'b0, core_timer_pkg::OFS_COUNT, 32'h0000_0000);
      chk((rdv - cnt_a) & 32'h0000_00FF, 32'h0000_0004);
      $display("test counter rate done");
      // Fastest periodic rate, interrupts still masked; an early tap is harmless.
      apb(1'b1, core_timer_pkg::OFS_WATCHDOG, 32'h0000_0000);
      apb(1'b1, core_timer_pkg::OFS_STATUS_CONTROL, 32'h0000_0000);
      // Overflow: poll for the flag, then enable, keep, clear and rewrite it.
      repeat (1000)
      begin
         apb(1'b0, core_timer_pkg::OFS_STATUS_CONTROL, 32'h0000_0000);
         if (rdv[core_timer_pkg::BIT_CORE_FLAG] === 1'b1)
            break;
      end
      chk(rdv & 32'h0000_00BF, 32'h0000_0080);
      chk({31'h0, core_irq}, 32'h0000_0000);
      apb(1'b1, core_timer_pkg::OFS_STATUS_CONTROL, 32'h0000_0020);
      @(posedge clk);
      chk({31'h0, core_irq}, 32'h0000_0001);
      apb(1'b1, core_timer_pkg::OFS_STATUS_CONTROL, 32'h0000_0000);
      rd_chk(core_timer_pkg::OFS_STATUS_CONTROL, 32'hFFFF_FFBF, 32'h0000_0080);
      apb(1'b1, core_timer_pkg::OFS_STATUS_CONTROL, 32'h0000_0028);
      @(posedge clk);
      chk({31'h0, core_irq}, 32'h0000_0000);
      rd_chk(core_timer_pkg::OFS_STATUS_CONTROL, 32'hFFFF_FFBF, 32'h0000_0020);
      apb(1'b1, core_timer_pkg::OFS_STATUS_CONTROL, 32'h0000_00A0);
      rd_chk(core_timer_pkg::OFS_STATUS_CONTROL, 32'hFFFF_FFBF, 32'h0000_0020);
      $display("test overflow flag done");
      // Unmapped address answers with an error and zero data.
      rd_chk(12'h010, 32'hFFFF_FFFF, 32'h0000_0000);
      chk({31'h0, errv}, 32'h0000_0001);
      $display("test unmapped access done");
      // Stop is honoured with the watchdog on, and turned into halt by the option.
      apb(1'b1, core_timer_pkg::OFS_OPTION, 32'h0000_0001);
      stop_exec <= 1'b1;
      repeat (3) @(posedge clk);
      chk({31'h0, stop_active}, 32'h0000_0001);
      stop_exec <= 1'b0;
      apb(1'b1, core_timer_pkg::OFS_OPTION, 32'h0000_0003);
      apb(1'b1, core_timer_pkg::OFS_WATCHDOG, 32'h0000_0000);
      stop_exec <= 1'b1;
      repeat (3) @(posedge clk);
      chk({31'h0, stop_active}, 32'h0000_0000);
      stop_exec <= 1'b0;
      hv_detect <= 1'b1;
      apb(1'b1, core_timer_pkg::OFS_WATCHDOG, 32'h0000_0000);
      hv_detect <= 1'b0;
      rd_chk(core_timer_pkg::OFS_WATCHDOG, 32'hFFFF_FFFF, 32'h0000_0000);
      rd_chk(core_timer_pkg::OFS_STATUS_CONTROL, 32'hFFFF_FF3F, 32'h0000_0020);
      $display("test stop and watchdog clear done");
      // Periodic: clear any stale flag, then time two requests 2^15 apart.
      apb(1'b1, core_timer_pkg::OFS_STATUS_CONTROL, 32'h0000_0014);
      apb(1'b1, core_timer_pkg::OFS_WATCHDOG, 32'h0000_0000);
      wait_irq(t1);
      apb(1'b1, core_timer_pkg::OFS_STATUS_CONTROL, 32'h0000_0014);
      @(posedge clk);
      chk({31'h0, periodic_irq}, 32'h0000_0000);
      rd_chk(core_timer_pkg::OFS_STATUS_CONTROL, 32'hFFFF_FF7F, 32'h0000_0010);
      wait_irq(t2);
      chk(t2 - t1, 32'h0000_8000);
      chk({31'h0, wd_seen}, 32'h0000_0000);
      $display("test periodic rate done");
      final_report();
   end
endmodule
`default_nettype wire
